/* hdl/cust_pkg.sv */
// package of shared constants for the control unit sense and timeout block
// assumes a 100 MHz core clock
package cust_pkg;
  // ---------------------------------------------------------------
  // sense byte 0 field positions
  // ---------------------------------------------------------------
  localparam int unsigned SNS_CMD_REJECT   = 0;
  localparam int unsigned SNS_INTERVENTION = 1;
  localparam int unsigned SNS_OUT_PARITY   = 2;
  localparam int unsigned SNS_EQUIP_FAULT  = 3;
  localparam int unsigned SNS_BAD_DATA     = 4;
  localparam int unsigned SNS_OVERRUN      = 5;
  localparam int unsigned SNS_COND_BITS    = 6;
  localparam logic [7:0]  SNS_RESET_VALUE  = 8'h00;
  localparam int unsigned SNS_EXTRA_MAX    = 31;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS     = 10000;
  localparam int unsigned SEL_FAST_NS       = 600;
  localparam int unsigned SEL_LIMIT_PS      = 1800000;
  localparam int unsigned SEQ_LIMIT_US      = 32;
  localparam int unsigned BURST_LIMIT_MS    = 500;
  localparam int unsigned SEL_FAST_CYC      = (SEL_FAST_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned SEL_LIMIT_CYC     = SEL_LIMIT_PS / CLK_PERIOD_PS;
  localparam int unsigned SEQ_LIMIT_CYC     = (SEQ_LIMIT_US * 1000000) / CLK_PERIOD_PS;
  localparam int unsigned BURST_LIMIT_CYC   = 50000000;
  localparam int unsigned TMR_WIDTH         = 26;
endpackage : cust_pkg

/* hdl/cust_sense.sv */
// sense byte 0 collection, early termination and interface timeouts
// assumes pin inputs are asynchronous and pass two flip-flops here;
// the command and data event strobes come from logic on core_clk
//
// Contract
// - sense byte 0 bits 0 to 5
// - reject unsupported or state-invalid commands
// - reject invalid command ordering
// - flag intervention for attention, not-ready, test, absent
// - flag outbound parity error on command or data
// - write parity error continues unless meaningless
// - parity-bad command code starts no operation
// - equipment fault flags and ends if fatal
// - bad data flags; may force read parity
// - data errors end only when fatal
// - overrun when channel answers service too late
// - overrun ends operation like stop
// - interlocked handshakes except when streaming
// - selection sequences within 32 microseconds
// - burst positioning adds under 500 milliseconds
// - burst transfer gap under 500 milliseconds
// - pass unwanted selection within 600 ns
// - own but unavailable device passes later
// - sense returns byte 0 plus extra bytes
// - bad command parity replaces sense only with check
module cust_sense (
  input  wire logic       core_clk,
  input  wire logic       resetn,
  input  wire logic       clk_en,
  input  wire logic       cmd_valid,
  input  wire logic       cmd_parity_ok,
  input  wire logic       cmd_supported,
  input  wire logic       cmd_state_ok,
  input  wire logic       cmd_order_ok,
  input  wire logic       cmd_is_sense,
  input  wire logic       cmd_no_reset,
  input  wire logic       data_valid,
  input  wire logic       data_parity_ok,
  input  wire logic       data_is_write,
  input  wire logic       parity_fatal,
  input  wire logic       data_bad,
  input  wire logic       data_sync_lost,
  input  wire logic       equip_fault,
  input  wire logic       equip_fatal,
  input  wire logic       dev_attention,
  input  wire logic       dev_not_ready,
  input  wire logic       dev_test_mode,
  input  wire logic       dev_absent,
  input  wire logic       svc_request,
  input  wire logic       svc_answered,
  input  wire logic       streaming,
  input  wire logic       burst_mode,
  input  wire logic       sense_done,
  input  wire logic [7:0] dev_sense_hi,
  input  wire logic       sel_in_pin,
  input  wire logic       addr_owned,
  input  wire logic       need_service,
  input  wire logic       sel_seq_active,
  input  wire logic       op_active,
  output logic      [7:0] sense_byte0,
  output logic            op_start,
  output logic            op_end_early,
  output logic            unit_check,
  output logic            force_parity,
  output logic            sel_pass_out,
  output logic            seq_timeout,
  output logic            burst_timeout
);
  // ---------------------------------------------------------------
  // synchronisers for pin inputs
  // ---------------------------------------------------------------
  logic [1:0] sel_sync_ff;
  logic [1:0] own_sync_ff;
  logic [1:0] svc_sync_ff;
  logic [1:0] ans_sync_ff;
  logic [1:0] att_sync_ff;
  logic [1:0] nrdy_sync_ff;
  logic [1:0] test_sync_ff;
  logic [1:0] abs_sync_ff;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sel_sync_ff  <= 2'h0;
      own_sync_ff  <= 2'h0;
      svc_sync_ff  <= 2'h0;
      ans_sync_ff  <= 2'h0;
      att_sync_ff  <= 2'h0;
      nrdy_sync_ff <= 2'h0;
      test_sync_ff <= 2'h0;
      abs_sync_ff  <= 2'h0;
    end else if (clk_en) begin
      sel_sync_ff  <= {sel_sync_ff[0], sel_in_pin};
      own_sync_ff  <= {own_sync_ff[0], addr_owned};
      svc_sync_ff  <= {svc_sync_ff[0], svc_request};
      ans_sync_ff  <= {ans_sync_ff[0], svc_answered};
      att_sync_ff  <= {att_sync_ff[0], dev_attention};
      nrdy_sync_ff <= {nrdy_sync_ff[0], dev_not_ready};
      test_sync_ff <= {test_sync_ff[0], dev_test_mode};
      abs_sync_ff  <= {abs_sync_ff[0], dev_absent};
    end
  end

  logic sel_s;
  logic own_s;
  logic svc_s;
  logic ans_s;
  logic unavail_s;
  assign sel_s     = sel_sync_ff[1];
  assign own_s     = own_sync_ff[1];
  assign svc_s     = svc_sync_ff[1];
  assign ans_s     = ans_sync_ff[1];
  assign unavail_s = nrdy_sync_ff[1] | test_sync_ff[1] | abs_sync_ff[1];

  // ---------------------------------------------------------------
  // command screening
  // ---------------------------------------------------------------
  logic cmd_rej;
  logic cmd_int;
  logic cmd_ok;
  assign cmd_rej = cmd_valid && cmd_parity_ok
                && (!cmd_supported || !cmd_state_ok || !cmd_order_ok);
  assign cmd_int = cmd_valid && cmd_parity_ok && !cmd_rej
                && (att_sync_ff[1] || unavail_s);
  assign cmd_ok  = cmd_valid && cmd_parity_ok && !cmd_rej && !cmd_int;
  assign op_start = clk_en && cmd_ok;

  // ---------------------------------------------------------------
  // overrun detection: service request unanswered past the limit while streaming
  // ---------------------------------------------------------------
  cust_tmr_if svc_tmr ();
  assign svc_tmr.run = svc_s && !ans_s && streaming;
  cust_watchdog #(
    .LIMIT (cust_pkg::TMR_WIDTH'(cust_pkg::SEQ_LIMIT_CYC))
  ) u_svc_wd (
    .core_clk (core_clk),
    .resetn   (resetn),
    .clk_en   (clk_en),
    .tmr      (svc_tmr)
  );
  logic overrun_evt;
  assign overrun_evt = svc_tmr.expired;

  // ---------------------------------------------------------------
  // sense condition bits
  // ---------------------------------------------------------------
  logic [cust_pkg::SNS_COND_BITS-1:0] sense_ff;
  logic [cust_pkg::SNS_COND_BITS-1:0] set_vec;
  logic                               par_evt;
  logic                               clr;

  assign par_evt = (cmd_valid && !cmd_parity_ok)
                || (data_valid && !data_parity_ok);
  assign clr = sense_done
            || (cmd_ok && !cmd_is_sense && !cmd_no_reset);

  always_comb begin
    set_vec = '0;
    set_vec[cust_pkg::SNS_CMD_REJECT]   = cmd_rej;
    set_vec[cust_pkg::SNS_INTERVENTION] = cmd_int;
    set_vec[cust_pkg::SNS_OUT_PARITY]   = par_evt;
    set_vec[cust_pkg::SNS_EQUIP_FAULT]  = equip_fault;
    set_vec[cust_pkg::SNS_BAD_DATA]     = data_valid && (data_bad || data_sync_lost);
    set_vec[cust_pkg::SNS_OVERRUN]      = overrun_evt;
  end

  // a parity-bad command, sense_done or an accepted command that is neither sense nor cmd_no_reset replaces old sense
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sense_ff <= cust_pkg::SNS_RESET_VALUE[cust_pkg::SNS_COND_BITS-1:0];
    end else if (clk_en) begin
      if (cmd_valid && !cmd_parity_ok) begin
        sense_ff <= set_vec;
      end else if (clr) begin
        sense_ff <= set_vec;
      end else begin
        sense_ff <= sense_ff | set_vec;
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sense_byte0 <= cust_pkg::SNS_RESET_VALUE;
    end else if (clk_en) begin
      sense_byte0 <= {dev_sense_hi[7:6], sense_ff};
    end
  end

  // ---------------------------------------------------------------
  // unit check and early termination
  // ---------------------------------------------------------------
  logic fatal_evt;
  assign fatal_evt = op_active && ((equip_fault && equip_fatal)
                  || (data_valid && data_sync_lost)
                  || (par_evt && data_is_write && parity_fatal)
                  || overrun_evt);

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      op_end_early <= 1'h0;
    end else if (clk_en) begin
      op_end_early <= fatal_evt;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      unit_check <= 1'h0;
    end else if (clk_en) begin
      if (cmd_rej || cmd_int || (cmd_valid && !cmd_parity_ok)) begin
        unit_check <= 1'h1;
      end else if (sense_done) begin
        unit_check <= 1'h0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      force_parity <= 1'h0;
    end else if (clk_en) begin
      force_parity <= data_valid && data_bad && !data_is_write;
    end
  end

  // ---------------------------------------------------------------
  // select propagation
  // ---------------------------------------------------------------
  logic pass_now;
  assign pass_now = sel_s && (!own_s || !need_service || unavail_s);

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sel_pass_out <= 1'h0;
    end else if (clk_en) begin
      sel_pass_out <= pass_now;
    end
  end

  // ---------------------------------------------------------------
  // sequence and burst watchdogs
  // ---------------------------------------------------------------
  cust_tmr_if seq_tmr ();
  assign seq_tmr.run = sel_seq_active;
  cust_watchdog #(
    .LIMIT (cust_pkg::TMR_WIDTH'(cust_pkg::SEQ_LIMIT_CYC))
  ) u_seq_wd (
    .core_clk (core_clk),
    .resetn   (resetn),
    .clk_en   (clk_en),
    .tmr      (seq_tmr)
  );

  cust_tmr_if gap_tmr ();
  assign gap_tmr.run = burst_mode && op_active && !data_valid;
  cust_watchdog #(
    .LIMIT (cust_pkg::TMR_WIDTH'(cust_pkg::BURST_LIMIT_CYC))
  ) u_gap_wd (
    .core_clk (core_clk),
    .resetn   (resetn),
    .clk_en   (clk_en),
    .tmr      (gap_tmr)
  );

  // selection sequence overran its budget
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      seq_timeout <= 1'h0;
    end else if (clk_en) begin
      seq_timeout <= seq_tmr.expired;
    end
  end

  // burst transfer gap overran its budget
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      burst_timeout <= 1'h0;
    end else if (clk_en) begin
      burst_timeout <= gap_tmr.expired;
    end
  end
endmodule : cust_sense

/* hdl/cust_tmr_if.sv */
// interface carrying one watchdog timer's controls and result
// assumes one clock domain shared by all users
interface cust_tmr_if;
  logic run;
  logic expired;
  modport owner (output run, input expired);
  modport timer (input run, output expired);
endinterface : cust_tmr_if

/* hdl/cust_watchdog.sv */
// watchdog counting cycles while run is high; expired once limit reached
// assumes the clock enable and reset of the sense block
module cust_watchdog #(
  parameter logic [cust_pkg::TMR_WIDTH-1:0] LIMIT = 26'h0000001
) (
  input  wire logic core_clk,
  input  wire logic resetn,
  input  wire logic clk_en,
  cust_tmr_if.timer tmr
);
  logic [cust_pkg::TMR_WIDTH-1:0] count_ff;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      count_ff <= '0;
    end else if (clk_en) begin
      if (!tmr.run) begin
        count_ff <= '0;
      end else if (count_ff != LIMIT) begin
        count_ff <= count_ff + 26'h0000001;
      end
    end
  end

  assign tmr.expired = tmr.run && (count_ff == LIMIT);
endmodule : cust_watchdog

/* verification/control_unit_sense_and_timeouts_test.sv */
// self-checking bench for cust_sense with a channel model
// assumes cust_pkg timing and a 100 MHz clock
module control_unit_sense_and_timeouts_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, resetn, clk_en, cmd_valid, cmd_parity_ok, cmd_supported;
  logic cmd_state_ok, cmd_order_ok, cmd_is_sense, cmd_no_reset, data_valid;
  logic data_parity_ok, data_is_write, parity_fatal, data_bad, data_sync_lost;
  logic equip_fault, equip_fatal, dev_attention, dev_not_ready, dev_test_mode;
  logic dev_absent, svc_request, svc_answered, streaming, burst_mode, sense_done;
  logic sel_in_pin, addr_owned, need_service, sel_seq_active, op_active, chan_slow;
  logic op_start, op_end_early, unit_check, force_parity, sel_pass_out, look;
  logic seq_timeout, burst_timeout;
  logic [7:0] dev_sense_hi, sense_byte0, hi8;
  logic [7:0] exp_q[$];
  int err_total, n_checks;
  cust_sense u_dut (.*);
  cust_chan_model u_chan (.*);
  always #5 core_clk = ~core_clk;
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    if (err_total == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // the monitor takes the oldest note whenever look is raised
  always @(posedge core_clk) begin
    if (look) chk("sense_byte0", sense_byte0, exp_q.pop_front());
  end
  // note a sense value, then clear it by a finished sense transfer
  task automatic expect_sense(input logic [7:0] v);
    exp_q.push_back(v | hi8);
    look = 1'b1;
    cyc(1);
    look = 1'b0;
    sense_done = 1'b1;
    cyc(1);
    sense_done = 1'b0;
    cyc(3);
    exp_q.push_back(hi8);
    look = 1'b1;
    cyc(1);
    look = 1'b0;
  endtask
  // row: parity ok, supported, state ok, order ok, four device pins
  task automatic issue(input logic [7:0] r);
    logic rej;
    logic intv;
    rej = !(r[6] & r[5] & r[4]);
    intv = |r[3:0];
    {dev_attention, dev_not_ready, dev_test_mode, dev_absent} = r[3:0];
    cyc(4);
    {cmd_parity_ok, cmd_supported, cmd_state_ok, cmd_order_ok} = r[7:4];
    cmd_valid = 1'b1;
    #1 chk("op_start", {7'h00, op_start}, {7'h00, r[7] & !rej & !intv});
    cyc(1);
    chk("unit_check", {7'h00, unit_check}, {7'h00, !r[7] | rej | intv});
    cmd_valid = 1'b0;
    {dev_attention, dev_not_ready, dev_test_mode, dev_absent} = 4'h0;
    cyc(2);
    expect_sense(r[7] ? {6'h00, intv, rej} : 8'h04);
  endtask
  // one data byte; wait a bounded time for an early end
  task automatic data_byte(input logic [3:0] f, input logic end_exp, input logic [7:0] s);
    int i;
    {data_parity_ok, data_bad, data_sync_lost, parity_fatal} = f;
    data_valid = 1'b1;
    cyc(1);
    chk("force_parity", {7'h00, force_parity}, {7'h00, f[2] & !data_is_write});
    data_valid = 1'b0;
    for (i = 0; i < 3 && !op_end_early; i++) cyc(1);
    chk("op_end_early", {7'h00, op_end_early}, {7'h00, end_exp});
    cyc(2);
    expect_sense(s);
  endtask
  initial begin
    int i;
    logic [7:0] rows[9];
    rows = '{8'hF0, 8'hB0, 8'hD0, 8'hE0, 8'h70,
             8'hF8, 8'hF4, 8'hF2, 8'hF1};
    {core_clk, resetn, clk_en, cmd_valid, cmd_is_sense, cmd_no_reset} = 6'h00;
    {data_valid, data_is_write, parity_fatal, data_bad, data_sync_lost} = 5'h00;
    {equip_fault, equip_fatal, dev_attention, dev_not_ready, dev_test_mode} = 5'h00;
    {dev_absent, svc_request, streaming, burst_mode, sense_done, sel_in_pin} = 6'h00;
    {addr_owned, need_service, sel_seq_active, op_active, chan_slow, look} = 6'h00;
    {cmd_parity_ok, cmd_supported, cmd_state_ok, cmd_order_ok, data_parity_ok} = 5'h1F;
    {err_total, n_checks} = 0;
    void'($urandom(32'hB7B6));
    dev_sense_hi = 8'($urandom());
    hi8 = {dev_sense_hi[7:6], 6'h00};
    repeat (12) @(negedge core_clk);
    resetn = 1'b1;
    cyc(2);
    clk_en = 1'b1;
    foreach (rows[k]) issue(rows[k]);
    op_active = 1'b1;
    burst_mode = 1'b1;
    data_is_write = 1'b1;
    data_byte(4'h4, 1'b0, 8'h14); // bad parity and data, write goes on
    data_byte(4'hA, 1'b1, 8'h10); // lost sync ends the operation
    data_is_write = 1'b0;
    data_byte(4'hC, 1'b0, 8'h10); // bad read data forces parity, read goes on
    chk("burst_timeout", {7'h00, burst_timeout}, 8'h00);
    burst_mode = 1'b0;
    equip_fault = 1'b1;
    equip_fatal = 1'b1;
    cyc(1);
    {equip_fault, equip_fatal} = 2'b00;
    cyc(3);
    expect_sense(8'h08);
    streaming = 1'b1;
    svc_request = 1'b1;
    cyc(100);
    svc_request = 1'b0;
    cyc(3);
    expect_sense(8'h00);
    chan_slow = 1'b1;
    svc_request = 1'b1;
    for (i = 0; i < 4000 && !op_end_early; i++) cyc(1);
    chk("overrun_end", {7'h00, op_end_early}, 8'h01);
    {svc_request, streaming, op_active} = 3'b000;
    cyc(3);
    expect_sense(8'h20);
    sel_in_pin = 1'b1;
    for (i = 0; i < 60 && !sel_pass_out; i++) cyc(1);
    chk("sel_pass_out", {7'h00, sel_pass_out}, 8'h01);
    sel_in_pin = 1'b0;
    cyc(5);
    sel_seq_active = 1'b1;
    cyc(cust_pkg::SEQ_LIMIT_CYC - 100);
    chk("seq_timeout", {7'h00, seq_timeout}, 8'h00);
    for (i = 0; i < 200 && !seq_timeout; i++) cyc(1);
    chk("seq_timeout", {7'h00, seq_timeout}, 8'h01);
    sel_seq_active = 1'b0;
    cyc(2);
    chk("seq_timeout", {7'h00, seq_timeout}, 8'h00);
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    err_total++;
    tally_and_finish();
  end
endmodule : control_unit_sense_and_timeouts_test

/* verification/cust_chan_model.sv */
// channel-side model answering device service requests
// assumes svc_request is driven on core_clk by the bench
module cust_chan_model (
  input  wire logic core_clk,
  input  wire logic resetn,
  input  wire logic svc_request,
  input  wire logic chan_slow,
  output logic      svc_answered
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [12:0] wait_ff;
  // answer held until the request drops; slow mode waits 5000 cycles
  // and never flags a malfunction of its own
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wait_ff      <= 13'h0000;
      svc_answered <= 1'b0;
    end else if (!svc_request) begin
      wait_ff      <= 13'h0000;
      svc_answered <= 1'b0;
    end else if (wait_ff == (chan_slow ? 13'h1388 : 13'h0002)) begin
      svc_answered <= 1'b1;
    end else begin
      wait_ff <= wait_ff + 13'h0001;
    end
  end
endmodule : cust_chan_model

/* verification/cust_sense_checker.sv */
// concurrent checks on the sense block's ports
// assumes it is bound onto cust_sense
module cust_sense_checker (
  input wire logic       core_clk,
  input wire logic       resetn,
  input wire logic       clk_en,
  input wire logic       cmd_valid,
  input wire logic       cmd_parity_ok,
  input wire logic       cmd_supported,
  input wire logic       cmd_order_ok,
  input wire logic       sense_done,
  input wire logic       equip_fault,
  input wire logic       equip_fatal,
  input wire logic       op_active,
  input wire logic       data_valid,
  input wire logic       data_is_write,
  input wire logic       data_bad,
  input wire logic       data_sync_lost,
  input wire logic       sel_seq_active,
  input wire logic       force_parity,
  input wire logic       seq_timeout,
  input wire logic       sel_in_pin,
  input wire logic       addr_owned,
  input wire logic [7:0] sense_byte0,
  input wire logic       op_start,
  input wire logic       op_end_early,
  input wire logic       unit_check,
  input wire logic       sel_pass_out
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  sequence s_bad_cmd;
    cmd_valid && clk_en && !cmd_parity_ok;
  endsequence
  sequence s_good_par;
    cmd_valid && clk_en && cmd_parity_ok;
  endsequence
  a_parity_no_start: assert property (s_bad_cmd |-> !op_start)
    else $error("op_start on bad command parity");
  a_parity_check: assert property (s_bad_cmd |=> unit_check ##1 sense_byte0[2])
    else $error("bad command parity not reported");
  a_reject_unsup: assert property (s_good_par ##0 !cmd_supported
    |-> !op_start ##2 sense_byte0[0])
    else $error("unsupported command not rejected");
  a_reject_order: assert property (s_good_par ##0 !cmd_order_ok
    |-> !op_start ##2 sense_byte0[0])
    else $error("bad command order not rejected");
  a_fatal_ends_op: assert property (equip_fault && equip_fatal && op_active && clk_en
    |=> op_end_early ##1 sense_byte0[3])
    else $error("fatal equipment fault did not end operation");
  a_sync_loss_ends: assert property (data_valid && clk_en && data_sync_lost && op_active
    |=> op_end_early ##1 sense_byte0[4])
    else $error("lost sync did not end operation");
  a_force_on_read: assert property (data_valid && clk_en && data_bad && !data_is_write
    |=> force_parity)
    else $error("bad read data did not force parity");
  a_seq_flag_cause: assert property ($rose(seq_timeout) |-> $past(sel_seq_active))
    else $error("sequence timeout without active sequence");
  a_overrun_ends: assert property ($rose(sense_byte0[5]) |-> $past(op_end_early))
    else $error("overrun without early end");
  a_check_hold: assert property ($fell(unit_check) |-> $past(sense_done))
    else $error("unit_check dropped without sense");
  a_sel_pass_fast: assert property ($rose(sel_in_pin) && !addr_owned && clk_en
    |-> ##[1:60] sel_pass_out)
    else $error("selection not passed within 600 ns");
endmodule : cust_sense_checker

bind cust_sense cust_sense_checker u_chk (.*);
